/* File: dv/gwr_regs_chk.sv */
// Purpose: port checker for gwr_regs
// Assumes: one clock, async high reset
// Notes: bound to the top module, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module gwr_regs_chk (
	// clock, reset, bus
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	// pad and events
	input wire logic pad_out,
	input wire logic pad_oe,
	input wire logic pad_pulldown,
	input wire logic first_led_pulse_out,
	input wire logic wdog_shutdown_event,
	input wire logic irq
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// a pin register write, and a watchdog write then its read
	sequence s_pin;
		wr && addr == gwr_pkg::OFF_PIN8;
	endsequence
	sequence s_wdrb;
		wr && addr == gwr_pkg::OFF_WDOG ##2 rd && addr == gwr_pkg::OFF_WDOG;
	endsequence
	a_dir_follows: assert property (s_pin |=> pad_oe == $past(wdata[2])) else $error("dir");
	a_pulldown_follows: assert property (s_pin |=> pad_pulldown == $past(wdata[3])) else $error("pd");
	a_led_routed: assert property (s_pin ##0 (wdata[5] && wdata[2]) |=> pad_out == first_led_pulse_out)
		else $error("led");
	a_set_routed: assert property (s_pin ##0 (!wdata[5] && wdata[2]) |=> pad_out == $past(wdata[0]))
		else $error("set");
	a_rsvd_reads_zero: assert property (rd && addr == gwr_pkg::OFF_RSVD |=> rdata == 8'h00) else $error("rsvd");
	a_wdog_readback: assert property (s_wdrb |=> rdata == {4'h0, $past(wdata[3:0], 3)}) else $error("wd");
	a_shutdown_pulse: assert property (wdog_shutdown_event |=> !wdog_shutdown_event) else $error("sd");
	a_mask_blocks: assert property (wr && addr == gwr_pkg::OFF_IRQ_MASK && wdata[1:0] == 2'h0 |=> !irq)
		else $error("mask");
endmodule
bind gwr_regs gwr_regs_chk gwr_regs_chk_i (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .pad_out, .pad_oe,
	.pad_pulldown, .first_led_pulse_out, .wdog_shutdown_event, .irq);
`default_nettype wire

/* File: dv/gwr_regs_tb_top.sv */
// Purpose: self-checking bench for gwr_regs
// Assumes: debounce 4/20 cycles, 2-cycle tick, so 5 s is 10000 cycles
// Notes: only the 5 s code is timed, longer codes would blow the run
`timescale 1ns/1ps
`default_nettype none
module gwr_regs_tb_top;
	localparam logic [7:0] P8 = gwr_pkg::OFF_PIN8;
	localparam logic [7:0] WD = gwr_pkg::OFF_WDOG;
	localparam logic [7:0] ST = gwr_pkg::OFF_IRQ_STATUS;
	localparam logic [7:0] MK = gwr_pkg::OFF_IRQ_MASK;
	logic clk, rst, wr, rd, pad_in, led, ext, pad_out, pad_oe, pad_pd, sd, irq;
	logic [7:0] addr, wdata, rdata, d;
	logic [2:0] boot_to;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;
	gwr_regs #(.DEB_SHORT(4), .DEB_LONG(20), .TICK(2)) gwr_regs_i (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
		.boot_wdog_timeout(boot_to), .pad_in, .pad_out, .pad_oe, .pad_pulldown(pad_pd),
		.first_led_pulse_out(led), .ext_irq_pending(ext), .wdog_shutdown_event(sd), .irq);
	task automatic report_and_stop;
		if (bad_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk8({7'h0, g}, {7'h0, e});
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask
	// bounded wait for shutdown (s=1) or for irq or shutdown (s=0)
	task automatic wait_ev(input logic s, output int k);
		k = 0;
		while ((s ? sd : irq | sd) !== 1'b1 && k < 10100)
		begin
			@(negedge clk);
			k++;
		end
	endtask
	task automatic t_regs;
		rd_reg(P8, d);
		chk8(d & 8'hfd, gwr_pkg::RST_PIN8 & 8'hfd);
		chk1(pad_pd, 1'b1);
		chk1(pad_oe, 1'b0);
		rd_reg(WD, d);
		chk8(d, 8'h01);
		wr_reg(gwr_pkg::OFF_BOOT, 8'hff);
		rd_reg(gwr_pkg::OFF_BOOT, d);
		chk8(d, 8'h3e);
		wr_reg(gwr_pkg::OFF_RSVD, 8'hff);
		rd_reg(gwr_pkg::OFF_RSVD, d);
		chk8(d, 8'h00);
		for (int i = 0; i < 16; i++)
		begin
			wr_reg(WD, 8'(i));
			rd_reg(WD, d);
			chk8(d, 8'(i));
		end
	endtask
	task automatic t_pin;
		wr_reg(P8, 8'hff);
		rd_reg(P8, d);
		chk8(d, 8'h3d);
		chk1(pad_out, 1'b0);
		@(posedge clk);
		led <= 1'b1;
		@(negedge clk);
		chk1(pad_out, 1'b1);
		wr_reg(P8, 8'h04);
		@(negedge clk);
		chk1(pad_out, 1'b0);
		chk1(pad_pd, 1'b0);
		chk1(pad_oe, 1'b1);
		wr_reg(P8, 8'h05);
		@(negedge clk);
		chk1(pad_out, 1'b1);
		wr_reg(8'h55, 8'hff);
		rd_reg(8'h55, d);
		chk8(d, 8'h00);
	endtask
	// pin change raises the pin interrupt after the chosen filter time
	task automatic t_deb;
		wr_reg(P8, 8'h00);
		wr_reg(MK, 8'h02);
		rd_reg(ST, d);
		@(posedge clk);
		pad_in <= 1'b1;
		repeat (12) @(negedge clk);
		chk1(irq, 1'b1);
		rd_reg(ST, d);
		chk8(d & 8'h02, 8'h02);
		chk1(irq, 1'b0);
		wr_reg(P8, 8'h10);
		pad_in <= 1'b0;
		repeat (12) @(negedge clk);
		chk1(irq, 1'b0);
		repeat (20) @(negedge clk);
		chk1(irq, 1'b1);
	endtask
	task automatic t_wdog;
		wr_reg(MK, 8'h01);
		wr_reg(WD, 8'h01);
		rd_reg(ST, d);
		wait_ev(1'b0, n);
		chk1(n >= 9990 && n <= 10010, 1'b1);
		// a late clear must restart the interval, so the next interrupt is a full period after it
		repeat (2000) @(negedge clk);
		rd_reg(ST, d);
		chk8(d & 8'h01, 8'h01);
		wait_ev(1'b0, n);
		chk1(n >= 9990 && n <= 10010, 1'b1);
		wait_ev(1'b1, n);
		chk1(n >= 9990 && n <= 10010, 1'b1);
		rd_reg(ST, d);
		wr_reg(WD, 8'h00);
		wait_ev(1'b0, n);
		chk1(n == 10100, 1'b1);
		wr_reg(WD, 8'h09);
		ext <= 1'b1;
		wait_ev(1'b1, n);
		chk1(n >= 9990 && n <= 10010, 1'b1);
		wr_reg(MK, 8'h00);
	endtask
	// mid-run reset with a different boot strap code
	task automatic t_boot;
		@(posedge clk);
		boot_to <= 3'h6;
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rd_reg(WD, d);
		chk8(d, 8'h06);
		chk1(pad_pd, 1'b1);
		chk1(pad_oe, 1'b0);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// hang guard, a full run needs about 53000 cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			bad_count++;
			report_and_stop();
		end
	end
	initial
	begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		pad_in = 1'b0;
		led = 1'b0;
		ext = 1'b0;
		boot_to = 3'h1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_regs();
		t_pin();
		t_deb();
		t_wdog();
		t_boot();
		report_and_stop();
	end
endmodule
`default_nettype wire

/* File: rtl/gwr_pkg.sv */
// Purpose: constants for the pin8 / watchdog configuration register bank
// Assumes: 40 MHz clock, 8-bit register port
// Notes: offsets are byte addresses on the plain register port
package gwr_pkg;
	// register offsets
	localparam logic [7:0] OFF_PIN8 = 8'h68;
	localparam logic [7:0] OFF_WDOG = 8'h69;
	localparam logic [7:0] OFF_BOOT = 8'h6a;
	localparam logic [7:0] OFF_RSVD = 8'h6b;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h70;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h71;
	// pin8 field positions
	localparam int BIT_SET = 0;
	localparam int BIT_STS = 1;
	localparam int BIT_DIR = 2;
	localparam int BIT_PDEN = 3;
	localparam int BIT_DEB = 4;
	localparam int BIT_SEL = 5;
	// watchdog and boot field positions
	localparam int BIT_MODE = 3;
	localparam int TIME_LSB = 0;
	localparam int BOOT_LSB = 1;
	// interrupt status bit positions
	localparam int IRQ_WDOG = 0;
	localparam int IRQ_PIN = 1;
	// reset values
	localparam logic [7:0] RST_PIN8 = 8'h0a;
	localparam logic [3:0] RST_WDOG_MODE = 4'h0;
	localparam logic [4:0] RST_BOOT = 5'h00;
	localparam logic [1:0] RST_IRQ_MASK = 2'h0;
	// timing
	localparam int CLK_HZ = 40000000;
	localparam real DEB_SHORT_US = 91.5;
	localparam int DEB_LONG_MS = 150;
	localparam int DEB_SHORT_CYC = int'($ceil(DEB_SHORT_US * CLK_HZ / 1.0e6));
	localparam int DEB_LONG_CYC = DEB_LONG_MS * (CLK_HZ / 1000);
	localparam int TICK_HZ = 1000;
	localparam int TICK_CYC = CLK_HZ / TICK_HZ;
	// watchdog intervals in seconds per code 1..7
	localparam int WD_S1 = 5;
	localparam int WD_S2 = 10;
	localparam int WD_S3 = 20;
	localparam int WD_S4 = 40;
	localparam int WD_S5 = 60;
	localparam int WD_S6 = 80;
	localparam int WD_S7 = 100;
	// watchdog mode encoding
	typedef enum logic {WD_PERIODIC = 1'b0, WD_IRQ_MODE = 1'b1} gwr_wdmode_t;
endpackage

/* File: rtl/gwr_regs.sv */
// Purpose: pin8 config, watchdog, boot-sequence version and reserved registers
// Assumes: single 40 MHz clock, synchronous pad input and led pulse input
// Notes: interrupt status is cleared by reading it; long counts are parameters;
//   status sits at 0x70 and mask at 0x71, bit 0 watchdog and bit 1 pin change;
//   the watchdog interval restarts on every write to the watchdog register
`timescale 1ns/1ps
`default_nettype none
module gwr_regs #(
	parameter int DEB_SHORT = gwr_pkg::DEB_SHORT_CYC,
	parameter int DEB_LONG = gwr_pkg::DEB_LONG_CYC,
	parameter int TICK = gwr_pkg::TICK_CYC
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// boot configuration
	input wire logic [2:0] boot_wdog_timeout,
	// pad
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe,
	output logic pad_pulldown,
	input wire logic first_led_pulse_out,
	// other device interrupts pending
	input wire logic ext_irq_pending,
	// events
	output logic wdog_shutdown_event,
	output logic irq
);
	// pin8 fields
	logic pin_out_value;
	logic pin_direction;
	logic pin_pulldown_enable;
	logic pin_debounce_select;
	logic pin_out_source;
	logic pin_level_status;

	// watchdog and boot fields
	logic wdog_mode_select;
	logic [2:0] wdog_timeout_select;
	logic [4:0] boot_seq_version_field;
	logic boot_loaded;

	// interrupt status and mask
	logic [1:0] irq_status;
	logic [1:0] irq_mask;

	// debounce filter
	logic [23:0] deb_cnt;
	logic [23:0] deb_limit;
	logic deb_done;

	// millisecond divider and interval counter
	logic [15:0] tick_cnt;
	logic tick;
	logic [16:0] ms_cnt;
	logic [16:0] limit_ms;
	logic restart;
	logic period_end;
	logic shutdown_due;

	// events and qualifiers
	logic wd_irq_ev;
	logic pin_ev;
	logic any_pending;

	// register decode
	logic wr_pin;
	logic wr_wdog;
	logic wr_boot;
	logic wr_mask;
	logic rd_stat;

	// one strobe per register except the reserved one (a read strobe for status); only exact offsets respond, so unmapped writes fall away
	assign wr_pin = wr && addr == gwr_pkg::OFF_PIN8;
	assign wr_wdog = wr && addr == gwr_pkg::OFF_WDOG;
	assign wr_boot = wr && addr == gwr_pkg::OFF_BOOT;
	assign wr_mask = wr && addr == gwr_pkg::OFF_IRQ_MASK;
	assign rd_stat = rd && addr == gwr_pkg::OFF_IRQ_STATUS;

	// pin8 configuration fields; status bit is not writable
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pin_out_value <= gwr_pkg::RST_PIN8[gwr_pkg::BIT_SET];
			pin_direction <= gwr_pkg::RST_PIN8[gwr_pkg::BIT_DIR];
			pin_pulldown_enable <= gwr_pkg::RST_PIN8[gwr_pkg::BIT_PDEN];
			pin_debounce_select <= gwr_pkg::RST_PIN8[gwr_pkg::BIT_DEB];
			pin_out_source <= gwr_pkg::RST_PIN8[gwr_pkg::BIT_SEL];
		end
		else if (wr_pin)
		begin
			pin_out_value <= wdata[gwr_pkg::BIT_SET];
			pin_direction <= wdata[gwr_pkg::BIT_DIR];
			pin_pulldown_enable <= wdata[gwr_pkg::BIT_PDEN];
			pin_debounce_select <= wdata[gwr_pkg::BIT_DEB];
			pin_out_source <= wdata[gwr_pkg::BIT_SEL];
		end
	end

	// pad drive: routed source whenever selected, independent of the direction bit
	assign pad_out = pin_out_source ? first_led_pulse_out : pin_out_value;
	assign pad_oe = pin_direction;
	assign pad_pulldown = pin_pulldown_enable;

	// filter threshold; the long setting needs 23 bits of the 24-bit counter
	assign deb_limit = pin_debounce_select ? 24'(DEB_LONG - 1) : 24'(DEB_SHORT - 1);
	assign deb_done = deb_cnt >= deb_limit;

	// debounce: level accepted only after it is stable for the selected time
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			deb_cnt <= 24'h000000;
			pin_level_status <= gwr_pkg::RST_PIN8[gwr_pkg::BIT_STS];
		end
		else if (pad_in == pin_level_status)
			deb_cnt <= 24'h000000;
		else if (deb_done)
		begin
			deb_cnt <= 24'h000000;
			pin_level_status <= pad_in;
		end
		else
			deb_cnt <= deb_cnt + 24'h000001;
	end

	// pin event fires in the cycle the filtered level flips
	assign pin_ev = (pad_in != pin_level_status) && deb_done;

	// watchdog fields; timeout loaded from boot strap after reset release
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wdog_mode_select <= gwr_pkg::RST_WDOG_MODE[gwr_pkg::BIT_MODE];
			wdog_timeout_select <= 3'h0;
			boot_loaded <= 1'b0;
		end
		else
		begin
			boot_loaded <= 1'b1;
			// the first edge after reset takes the boot strap; a write there is dropped
			if (!boot_loaded)
				wdog_timeout_select <= boot_wdog_timeout;
			else if (wr_wdog)
			begin
				wdog_mode_select <= wdata[gwr_pkg::BIT_MODE];
				wdog_timeout_select <= wdata[gwr_pkg::TIME_LSB +: 3];
			end
		end
	end

	// boot-sequence version field, plain read and write
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			boot_seq_version_field <= gwr_pkg::RST_BOOT;
		else if (wr_boot)
			boot_seq_version_field <= wdata[gwr_pkg::BOOT_LSB +: 5];
	end

	// interval in milliseconds per timeout code
	always_comb
	begin
		case (wdog_timeout_select)
			3'h1: limit_ms = 17'(gwr_pkg::WD_S1 * gwr_pkg::TICK_HZ);
			3'h2: limit_ms = 17'(gwr_pkg::WD_S2 * gwr_pkg::TICK_HZ);
			3'h3: limit_ms = 17'(gwr_pkg::WD_S3 * gwr_pkg::TICK_HZ);
			3'h4: limit_ms = 17'(gwr_pkg::WD_S4 * gwr_pkg::TICK_HZ);
			3'h5: limit_ms = 17'(gwr_pkg::WD_S5 * gwr_pkg::TICK_HZ);
			3'h6: limit_ms = 17'(gwr_pkg::WD_S6 * gwr_pkg::TICK_HZ);
			3'h7: limit_ms = 17'(gwr_pkg::WD_S7 * gwr_pkg::TICK_HZ);
			default: limit_ms = 17'h00000;
		endcase
	end

	// millisecond tick divider
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tick_cnt <= 16'h0000;
		else if (tick)
			tick_cnt <= 16'h0000;
		else
			tick_cnt <= tick_cnt + 16'h0001;
	end

	// one-cycle enable every millisecond; the watchdog interval counter counts these, the debounce counts clock cycles
	assign tick = tick_cnt == 16'(TICK - 1);

	// in interrupt mode the count runs only while something is pending
	assign any_pending = ext_irq_pending || (irq_status != 2'h0);

	// a clear of the watchdog bit, any watchdog write or the boot load start a fresh interval
	assign restart = (rd_stat && irq_status[gwr_pkg::IRQ_WDOG]) || wr_wdog || !boot_loaded;

	// last tick of the interval; code zero never ends a period
	assign period_end = tick && (ms_cnt + 17'h00001 >= limit_ms) && (wdog_timeout_select != 3'h0);

	// interval counter
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ms_cnt <= 17'h00000;
		else if (restart || wdog_timeout_select == 3'h0)
			ms_cnt <= 17'h00000;
		// idle in interrupt mode: nothing pending means nothing to time
		else if (wdog_mode_select == gwr_pkg::WD_IRQ_MODE && !any_pending)
			ms_cnt <= 17'h00000;
		else if (period_end)
			ms_cnt <= 17'h00000;
		else if (tick)
			ms_cnt <= ms_cnt + 17'h00001;
	end

	// periodic mode announces each period end as an interrupt
	assign wd_irq_ev = period_end && wdog_mode_select == gwr_pkg::WD_PERIODIC;

	// a clear in the very cycle the period ends still counts as in time
	assign shutdown_due = period_end && !restart &&
		(wdog_mode_select == gwr_pkg::WD_IRQ_MODE || irq_status[gwr_pkg::IRQ_WDOG]);

	// shutdown pulse: periodic with old interrupt still set, or pending too long
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wdog_shutdown_event <= 1'b0;
		else
			wdog_shutdown_event <= shutdown_due;
	end

	// sticky status; a new event wins over the clear on read
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irq_status <= 2'h0;
		else
		begin
			if (rd_stat)
				irq_status <= 2'h0;
			// later assignments win: an event in the clearing cycle survives
			if (wd_irq_ev)
				irq_status[gwr_pkg::IRQ_WDOG] <= 1'b1;
			if (pin_ev)
				irq_status[gwr_pkg::IRQ_PIN] <= 1'b1;
		end
	end

	// interrupt mask
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irq_mask <= gwr_pkg::RST_IRQ_MASK;
		else if (wr_mask)
			irq_mask <= wdata[1:0];
	end

	// level output while any unmasked status bit is set
	assign irq = |(irq_status & irq_mask);

	// read data one cycle after the strobe; unmapped and reserved read zero
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= 8'h00;
		else if (rd)
		begin
			case (addr)
				gwr_pkg::OFF_PIN8: rdata <= {2'h0, pin_out_source, pin_debounce_select, pin_pulldown_enable,
					pin_direction, pin_level_status, pin_out_value};
				gwr_pkg::OFF_WDOG: rdata <= {4'h0, wdog_mode_select, wdog_timeout_select};
				gwr_pkg::OFF_BOOT: rdata <= {2'h0, boot_seq_version_field, 1'b0};
				gwr_pkg::OFF_IRQ_STATUS: rdata <= {6'h00, irq_status};
				gwr_pkg::OFF_IRQ_MASK: rdata <= {6'h00, irq_mask};
				default: rdata <= 8'h00;
			endcase
		end
		else
			rdata <= 8'h00;
	end
endmodule
`default_nettype wire
